//--- src/ptd_pkg.sv
// Purpose: shared constants and carrier types for the port transition detect block
// Assumes: registers are reached through an already decoded register access port
// Notes: addresses are the serial register address codes
package ptd_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h02;
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_MONITOR_MASK = 8'h06;
  localparam logic [7:0] ADDR_DISPLAY_TEST = 8'h07;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_INDIV_BIT = 6;
  localparam int CFG_MONITOR_BIT = 7;
  localparam int MASK_FLAG_BIT = 7;
  localparam int DTEST_BIT = 0;
  localparam int CODE_W = 4;
  localparam int MON_PORTS = 7;
  localparam int LED_PORTS = 28;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_GLOBAL_CODE = 4'h0;
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_INDIV = 1'b0;
  localparam logic [6:0] RST_MASK = 7'h00;
  localparam logic RST_DTEST = 1'b0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } reg_rsp_t;

  typedef struct packed {
    logic run;
    logic indiv_mode;
    logic [3:0] global_code;
    logic test_half;
  } drive_ctl_t;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_ARMED,
    MON_FLAGGED
  } mon_state_t;

endpackage

//--- src/level_sync.sv
// Purpose: two flip-flop synchroniser for the monitored port levels
// Assumes: reset is the already released synchronous copy
// Notes: only the second stage may be read by other logic
module level_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [ptd_pkg::MON_PORTS-1:0] level_async,
  output logic [ptd_pkg::MON_PORTS-1:0] level_sync_q
);
  import ptd_pkg::*;

  logic [MON_PORTS-1:0] meta;

  for (genvar i = 0; i < MON_PORTS; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        level_sync_q[i] <= 1'b0;
      end else begin
        meta[i] <= level_async[i];
        level_sync_q[i] <= meta[i];
      end
    end
  end

endmodule

//--- src/port_transition_detect.sv
// Purpose: port change monitor, global drive code and display test override
// Assumes: serial interface delivers one-cycle read and write strobes per register access
// Notes: all outputs are registered
//
// How it works
// - config bit 7 arms change detection
// - mask bits select monitored ports
// - detection ignores port direction
// - each armed config write reloads snapshot
// - armed until disarm write or change
// - arming drives flag and pin low
// - any difference sets flag and pin high
// - flag holds through later changes
// - only mask access or arming write clears flag
// - clearing flag by mask access leaves detection off
// - low four bits give drive code
// - display test forces LED ports on
// - GPIO ports untouched by display test
// - display test uses half current
// - config bit 0 is run bit
// - config bit 6 selects current mode
// - reset clears mask, disarms, shuts down
module port_transition_detect (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register access
  input wire ptd_pkg::reg_req_t req,
  output ptd_pkg::reg_rsp_t rsp,
  // monitored port levels
  input wire logic [ptd_pkg::MON_PORTS-1:0] port_level,
  // flag pin
  input wire logic flag_int_enable,
  output logic flag_port_out,
  output logic flag_port_oe,
  // led ports
  input wire logic [ptd_pkg::LED_PORTS-1:0] led_cfg,
  input wire logic [ptd_pkg::LED_PORTS-1:0] led_port_on,
  output logic [ptd_pkg::LED_PORTS-1:0] led_drive_on,
  output ptd_pkg::drive_ctl_t drive_ctl
);
  import ptd_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // port synchroniser
  // ****************************************
  logic [MON_PORTS-1:0] level_now;

  level_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .level_async(port_level),
    .level_sync_q(level_now)
  );

  // ****************************************
  // access decode
  // ****************************************
  logic cfg_wr;
  logic cfg_arm;
  logic mask_acc;

  assign cfg_wr = req.wr && (req.addr == ADDR_DEVICE_CONFIG);
  assign cfg_arm = cfg_wr && req.wdata[CFG_MONITOR_BIT];
  assign mask_acc = (req.wr || req.rd) && (req.addr == ADDR_MONITOR_MASK);

  // ****************************************
  // software registers
  // ****************************************
  logic [3:0] global_code;
  logic run;
  logic indiv_mode;
  logic monitor_en;
  logic [6:0] mask;
  logic dtest;
  logic [3:0] next_global_code;
  logic next_run;
  logic next_indiv_mode;
  logic next_monitor_en;
  logic [6:0] next_mask;
  logic next_dtest;

  always_comb begin
    next_global_code = global_code;
    next_run = run;
    next_indiv_mode = indiv_mode;
    next_monitor_en = monitor_en;
    next_mask = mask;
    next_dtest = dtest;
    if (req.wr) begin
      unique case (req.addr)
        ADDR_GLOBAL_CURRENT: begin
          // upper nibble is not stored
          next_global_code = req.wdata[CODE_W-1:0];
        end
        ADDR_DEVICE_CONFIG: begin
          next_run = req.wdata[CFG_RUN_BIT];
          next_indiv_mode = req.wdata[CFG_INDIV_BIT];
          next_monitor_en = req.wdata[CFG_MONITOR_BIT];
        end
        ADDR_MONITOR_MASK: begin
          next_mask = req.wdata[MON_PORTS-1:0];
        end
        ADDR_DISPLAY_TEST: begin
          next_dtest = req.wdata[DTEST_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_code <= RST_GLOBAL_CODE;
      run <= RST_RUN;
      indiv_mode <= RST_INDIV;
      monitor_en <= 1'b0;
      mask <= RST_MASK;
      dtest <= RST_DTEST;
    end else begin
      global_code <= next_global_code;
      run <= next_run;
      indiv_mode <= next_indiv_mode;
      monitor_en <= next_monitor_en;
      mask <= next_mask;
      dtest <= next_dtest;
    end
  end

  // ****************************************
  // change monitor
  // ****************************************
  // the compare uses the pin level only, so output ports are watched too
  mon_state_t state;
  mon_state_t next_state;
  logic [6:0] snap;
  logic [6:0] next_snap;
  logic change;
  logic flag;

  assign change = |((level_now ^ snap) & mask);
  assign flag = (state == MON_FLAGGED);

  always_comb begin
    next_state = state;
    next_snap = snap;
    if (cfg_arm) begin
      next_snap = level_now;
    end
    unique case (state)
      MON_IDLE: begin
        if (cfg_arm) begin
          next_state = MON_ARMED;
        end
      end
      MON_ARMED: begin
        // a config write in the same cycle as a change wins: arming takes a fresh snapshot, disarming goes idle
        if (cfg_wr) begin
          next_state = cfg_arm ? MON_ARMED : MON_IDLE;
        end else if (change) begin
          next_state = MON_FLAGGED;
        end
      end
      MON_FLAGGED: begin
        if (cfg_arm) begin
          next_state = MON_ARMED;
        end else if (mask_acc) begin
          next_state = MON_IDLE;
        end
      end
      default: begin
        next_state = MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MON_IDLE;
      snap <= 7'h00;
    end else begin
      state <= next_state;
      snap <= next_snap;
    end
  end

  // ****************************************
  // flag pin
  // ****************************************
  // pin direction is owned by the port configuration outside this block
  logic next_flag_port_out;

  always_comb begin
    next_flag_port_out = flag_int_enable && (next_state == MON_FLAGGED);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_port_out <= 1'b0;
      flag_port_oe <= 1'b0;
    end else begin
      flag_port_out <= next_flag_port_out;
      flag_port_oe <= flag_int_enable;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  reg_rsp_t next_rsp;

  always_comb begin
    next_rsp.valid = req.rd;
    next_rsp.data = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_GLOBAL_CURRENT: next_rsp.data = {4'h0, global_code};
        ADDR_DEVICE_CONFIG: next_rsp.data = {monitor_en, indiv_mode, 5'h00, run};
        ADDR_MONITOR_MASK: next_rsp.data = {flag, mask};
        ADDR_DISPLAY_TEST: next_rsp.data = {7'h00, dtest};
        default: next_rsp.data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // ****************************************
  // led drive and current control
  // ****************************************
  // display test ignores run and port bits but never touches stored values
  logic [LED_PORTS-1:0] next_led_drive_on;
  drive_ctl_t next_drive_ctl;

  always_comb begin
    next_led_drive_on = led_cfg & ({LED_PORTS{dtest}} | ({LED_PORTS{run}} & led_port_on));
    next_drive_ctl.run = run;
    next_drive_ctl.indiv_mode = indiv_mode;
    next_drive_ctl.global_code = global_code;
    next_drive_ctl.test_half = dtest;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_drive_on <= '0;
      drive_ctl <= '0;
    end else begin
      led_drive_on <= next_led_drive_on;
      drive_ctl <= next_drive_ctl;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_arm_write;
    cfg_arm;
  endsequence

  sequence s_flag_read;
    req.rd && (req.addr == ADDR_MONITOR_MASK) && flag && !cfg_arm;
  endsequence

  a_arm_enables: assert property (s_arm_write |=> state == MON_ARMED && monitor_en)
    else $error("arming write did not arm the monitor");

  a_snap_reload: assert property (s_arm_write |=> snap == $past(level_now))
    else $error("snapshot not reloaded on arming write");

  a_arm_clears: assert property (s_arm_write |=> !flag_port_out && !flag)
    else $error("flag pin not low after arming");

  a_disarm_write: assert property (state == MON_ARMED && cfg_wr && !cfg_arm |=> state == MON_IDLE)
    else $error("disarm write left monitor armed");

  a_masked_quiet: assert property (state == MON_ARMED && !change && !cfg_wr |=> !flag)
    else $error("flag set without a selected change");

  a_change_flags: assert property (state == MON_ARMED && change && !cfg_wr
    |=> flag && (flag_port_out == $past(flag_int_enable)))
    else $error("change not flagged");

  a_flag_holds: assert property (flag && !mask_acc && !cfg_arm |=> flag)
    else $error("flag dropped without mask access");

  a_read_twice: assert property (s_flag_read |=> rsp.valid && rsp.data[MASK_FLAG_BIT] && !flag)
    else $error("mask read did not report then clear flag");

  a_one_shot: assert property (flag && mask_acc && !cfg_arm
    |=> (state == MON_IDLE) [*2] or (state == MON_IDLE ##1 $past(cfg_arm)))
    else $error("detection resumed without arming write");

  a_test_drive: assert property (dtest |=> (led_drive_on == $past(led_cfg)) && drive_ctl.test_half)
    else $error("display test did not drive all led ports");

  a_gpio_idle: assert property ((led_drive_on & ~$past(led_cfg)) == '0)
    else $error("non-led port driven");

endmodule

//--- tb/host_model.sv
// Purpose: host side of the register port, issuing one-cycle access strobes
// Assumes: requests change on the falling edge; read data arrives one cycle after rd
// Notes: released address and data lines show the inverse of the last value
module host_model (
  // clock
  input wire logic clk,
  // register access
  output ptd_pkg::reg_req_t req,
  input wire ptd_pkg::reg_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptd_pkg::*;

  // ****************************************
  // access tasks
  // ****************************************
  initial req = '0;

  // one strobe per completed access, as the serial side would give
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.rd = 1'b1;
    @(posedge clk);
    #1;
    // the answer stands for one cycle only, so take it right after the strobe edge
    // a missing answer reads as unknown so it can never match
    d = (rsp.valid === 1'b1) ? rsp.data : 8'hxx;
    @(negedge clk);
    req.rd = 1'b0;
    req.addr = ~a;
  endtask
endmodule

//--- tb/port_transition_detect_test.sv
// Purpose: self-checking bench for the port change monitor and drive controls
// Assumes: host model drives the register port; bench drives ports on falling edges
// Notes: change latency covered by waiting five edges after each level change
module port_transition_detect_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ptd_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic clk;
  logic arst_n;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [6:0] port_level;
  logic flag_int_enable;
  logic flag_port_out;
  logic flag_port_oe;
  logic [27:0] led_cfg;
  logic [27:0] led_port_on;
  logic [27:0] led_drive_on;
  drive_ctl_t drive_ctl;
  int bad_count;
  int check_count;
  logic [7:0] rd_v;
  logic [7:0] d;
  logic [6:0] m;
  logic [6:0] lv;

  host_model host_u (.clk(clk), .req(req), .rsp(rsp));

  port_transition_detect dut_u (
    .clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp), .port_level(port_level),
    .flag_int_enable(flag_int_enable), .flag_port_out(flag_port_out),
    .flag_port_oe(flag_port_oe), .led_cfg(led_cfg), .led_port_on(led_port_on),
    .led_drive_on(led_drive_on), .drive_ctl(drive_ctl)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [27:0] exp_led(logic [27:0] cf, logic [27:0] on, logic r, logic t);
    return cf & ({28{t}} | ({28{r}} & on));
  endfunction

  function automatic logic [7:0] exp_cfg(logic [7:0] w);
    return {w[7:6], 5'h00, w[0]};
  endfunction

  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(string what, logic [7:0] a, logic [7:0] e);
    host_u.reg_read(a, rd_v);
    check(what, e, rd_v);
  endtask

  // level change plus enough edges for the synchroniser and the flag
  task automatic set_lv(logic [6:0] v);
    @(negedge clk);
    port_level = v;
    settle(5);
  endtask

  task automatic test_end(string name);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the tests need well under 5000 cycles
  initial begin
    #(20000 * 40);
    bad_count++;
    summarize();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    arst_n = 1'b0;
    port_level = 7'h00;
    flag_int_enable = 1'b0;
    led_cfg = '0;
    led_port_on = '0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'h505d));
    repeat (8) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    settle(4);
    rd_chk("cfg reset", ADDR_DEVICE_CONFIG, 8'h00);
    rd_chk("mask reset", ADDR_MONITOR_MASK, 8'h00);
    check("run reset", 0, drive_ctl);
    host_u.reg_write(8'h05, 8'hff);
    rd_chk("unmapped", 8'h05, 8'h00);
    test_end("reset");

    for (int i = 0; i < 16; i++) begin
      d = {4'($urandom), 4'(i)};
      host_u.reg_write(ADDR_GLOBAL_CURRENT, d);
      settle(2);
      check("global code", d[3:0], drive_ctl.global_code);
      rd_chk("global read", ADDR_GLOBAL_CURRENT, {4'h0, d[3:0]});
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'h7f;
      host_u.reg_write(ADDR_DEVICE_CONFIG, d);
      settle(2);
      check("run bit", d[0], drive_ctl.run);
      check("indiv mode", d[6], drive_ctl.indiv_mode);
      rd_chk("cfg read", ADDR_DEVICE_CONFIG, exp_cfg(d));
    end
    test_end("controls");

    // mask first, pin enable next, arm last
    lv = 7'($urandom);
    m = 7'($urandom) | 7'h01;
    m[6] = 1'b0;
    set_lv(lv);
    host_u.reg_write(ADDR_MONITOR_MASK, {1'b1, m});
    rd_chk("mask read", ADDR_MONITOR_MASK, {1'b0, m});
    @(negedge clk);
    flag_int_enable = 1'b1;
    settle(2);
    check("pin enable", 1, flag_port_oe);
    host_u.reg_write(ADDR_DEVICE_CONFIG, 8'h80);
    set_lv(lv ^ 7'h40);
    check("masked port", 0, flag_port_out);
    set_lv(lv ^ 7'h41);
    check("flag set", 1, flag_port_out);
    set_lv(lv);
    check("flag held", 1, flag_port_out);
    rd_chk("first read", ADDR_MONITOR_MASK, {1'b1, m});
    settle(1);
    check("pin cleared", 0, flag_port_out);
    rd_chk("second read", ADDR_MONITOR_MASK, {1'b0, m});
    set_lv(lv ^ 7'h01);
    rd_chk("one shot", ADDR_MONITOR_MASK, {1'b0, m});
    rd_chk("m bit kept", ADDR_DEVICE_CONFIG, 8'h80);
    host_u.reg_write(ADDR_DEVICE_CONFIG, 8'h80);
    settle(5);
    check("fresh snapshot", 0, flag_port_out);
    @(negedge clk);
    port_level = lv;
    @(negedge clk);
    port_level = lv ^ 7'h01;
    settle(5);
    check("pulse caught", 1, flag_port_out);
    @(negedge clk);
    flag_int_enable = 1'b0;
    settle(2);
    check("pin disabled", 0, flag_port_out);
    check("oe off", 0, flag_port_oe);
    @(negedge clk);
    flag_int_enable = 1'b1;
    host_u.reg_write(ADDR_DEVICE_CONFIG, 8'h80);
    settle(2);
    check("arm clears", 0, flag_port_out);
    host_u.reg_write(ADDR_DEVICE_CONFIG, 8'h00);
    set_lv(lv);
    check("disarmed", 0, flag_port_out);
    rd_chk("no flag", ADDR_MONITOR_MASK, {1'b0, m});
    test_end("monitor");

    host_u.reg_write(ADDR_GLOBAL_CURRENT, 8'h0a);
    for (int i = 0; i < 8; i++) begin
      host_u.reg_write(ADDR_DEVICE_CONFIG, {7'h00, i[0]});
      host_u.reg_write(ADDR_DISPLAY_TEST, {7'h00, i[1]});
      @(negedge clk);
      led_cfg = 28'($urandom);
      led_port_on = 28'($urandom);
      settle(3);
      check("led drive", exp_led(led_cfg, led_port_on, i[0], i[1]), led_drive_on);
      check("half current", i[1], drive_ctl.test_half);
      check("run kept", i[0], drive_ctl.run);
      rd_chk("code kept", ADDR_GLOBAL_CURRENT, 8'h0a);
      rd_chk("test read", ADDR_DISPLAY_TEST, {7'h00, i[1]});
    end
    test_end("display test");
    summarize();
  end
endmodule
